// file: core_instr_subset_exec.v
// Executor for a subset of the 8-bit core instruction set, with its register port.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "instr_subset_consts.vh"

module core_instr_subset_exec #(
  parameter DATA_W = 8,
  parameter ADDR_W = 7,
  parameter PC_W = 13,
  parameter INSTR_W = 14
) (
  input wire clk_i,
  input wire reset_i,
  input wire instr_valid_i,
  input wire [INSTR_W-1:0] instr_i,
  output wire instr_ready_o,
  output wire [PC_W-1:0] pc_o,
  output wire pc_load_o,
  input wire [7:0] pc_upper_latch_i,
  output wire [ADDR_W-1:0] file_addr_o,
  output wire file_rd_o,
  input wire [DATA_W-1:0] file_rdata_i,
  output wire file_wr_o,
  output wire [DATA_W-1:0] file_wdata_o,
  output wire [DATA_W-1:0] acc_o,
  output wire zero_o,
  output wire retire_o,
  output wire discard_o,
  input wire [1:0] bus_addr_i,
  input wire [31:0] bus_wdata_i,
  input wire bus_wr_i,
  input wire bus_rd_i,
  output wire [31:0] bus_rdata_o
);

  localparam S_IDLE = 2'h0;
  localparam S_RD = 2'h1;
  localparam S_DATA = 2'h2;

  localparam OP_NONE = 3'h0;
  localparam OP_CLEAR_ACC = 3'h1;
  localparam OP_CLEAR_FILE = 3'h2;
  localparam OP_DEC = 3'h3;
  localparam OP_DEC_SKIP = 3'h4;
  localparam OP_INC_SKIP = 3'h5;
  localparam OP_BRANCH = 3'h6;
  localparam OP_OR_LIT = 3'h7;

  // Unknown encodings fall to OP_NONE and retire; their only effect is to set the sticky unsupported status bit.
  function [2:0] decode;
    input [INSTR_W-1:0] w;
    begin
      if ((w & `CLEAR_ACC_MASK) == `CLEAR_ACC_PAT)
        decode = OP_CLEAR_ACC;
      else if ((w & `CLEAR_FILE_MASK) == `CLEAR_FILE_PAT)
        decode = OP_CLEAR_FILE;
      else if ((w & `DEC_MASK) == `DEC_PAT)
        decode = OP_DEC;
      else if ((w & `DEC_SKIP_MASK) == `DEC_SKIP_PAT)
        decode = OP_DEC_SKIP;
      else if ((w & `INC_SKIP_MASK) == `INC_SKIP_PAT)
        decode = OP_INC_SKIP;
      else if ((w & `BRANCH_MASK) == `BRANCH_PAT)
        decode = OP_BRANCH;
      else if ((w & `OR_LIT_MASK) == `OR_LIT_PAT)
        decode = OP_OR_LIT;
      else
        decode = OP_NONE;
    end
  endfunction

  // Every output is a register, so each result shows one cycle after the edge that decides it.
  reg [1:0] state_r, state_nxt;
  reg [2:0] op_r, op_nxt;
  reg dest_r, dest_nxt;
  reg [ADDR_W-1:0] addr_r, addr_nxt;
  reg [DATA_W-1:0] acc_r, acc_nxt;
  reg zero_r, zero_nxt;
  reg [PC_W-1:0] pc_r, pc_nxt;
  reg pc_load_r, pc_load_nxt;
  reg file_rd_r, file_rd_nxt;
  reg file_wr_r, file_wr_nxt;
  reg [DATA_W-1:0] wdata_r, wdata_nxt;
  reg skip_r, skip_nxt;
  reg retire_r, retire_nxt;
  reg discard_r, discard_nxt;
  reg unsup_r, unsup_nxt;
  reg enable_r, enable_nxt;
  reg ready_r, ready_nxt;
  reg [31:0] rdata_r, rdata_nxt;
  reg acc_hit;

  wire accept = instr_valid_i & ready_r;
  wire [2:0] op_dec = decode(instr_i);
  // Operand data is taken exactly one cycle after the read strobe; the file has no wait input.
  wire [DATA_W-1:0] dec_val = file_rdata_i - {{(DATA_W-1){1'b0}}, 1'b1};
  wire [DATA_W-1:0] inc_val = file_rdata_i + {{(DATA_W-1){1'b0}}, 1'b1};
  wire [DATA_W-1:0] result = (op_r == OP_INC_SKIP) ? inc_val : dec_val;
  wire [DATA_W-1:0] or_val = acc_r | instr_i[DATA_W-1:0];

  always @*
  begin
    state_nxt = state_r;
    op_nxt = op_r;
    dest_nxt = dest_r;
    addr_nxt = addr_r;
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    pc_nxt = pc_r;
    pc_load_nxt = 1'b0;
    file_rd_nxt = 1'b0;
    file_wr_nxt = 1'b0;
    wdata_nxt = wdata_r;
    skip_nxt = skip_r;
    retire_nxt = 1'b0;
    discard_nxt = 1'b0;
    unsup_nxt = unsup_r;
    enable_nxt = enable_r;
    acc_hit = 1'b0;
    if (bus_wr_i && bus_addr_i == `REG_CTRL_OFS)
      enable_nxt = bus_wdata_i[`CTRL_ENABLE_BIT];
    case (state_r)
      S_IDLE:
      begin
        if (accept)
        begin
          pc_nxt = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
          retire_nxt = 1'b1;
          if (skip_r)
          begin
            // The slot after a taken skip or a branch runs as a no-operation.
            skip_nxt = 1'b0;
            discard_nxt = 1'b1;
          end
          else
          begin
            case (op_dec)
              OP_CLEAR_ACC:
              begin
                acc_nxt = {DATA_W{1'b0}};
                acc_hit = 1'b1;
                zero_nxt = 1'b1;
              end
              OP_CLEAR_FILE:
              begin
                addr_nxt = instr_i[ADDR_W-1:0];
                wdata_nxt = {DATA_W{1'b0}};
                file_wr_nxt = 1'b1;
                zero_nxt = 1'b1;
              end
              OP_DEC, OP_DEC_SKIP, OP_INC_SKIP:
              begin
                // Read-modify-write needs the operand first, so retire waits for the data.
                retire_nxt = 1'b0;
                op_nxt = op_dec;
                dest_nxt = instr_i[`DEST_BIT];
                addr_nxt = instr_i[ADDR_W-1:0];
                file_rd_nxt = 1'b1;
                state_nxt = S_RD;
              end
              OP_BRANCH:
              begin
                pc_nxt = {pc_upper_latch_i[`UPPER_LATCH_HI:`UPPER_LATCH_LO], instr_i[10:0]};
                pc_load_nxt = 1'b1;
                // The word already fetched is stale; burning it gives the second cycle.
                skip_nxt = 1'b1;
              end
              OP_OR_LIT:
              begin
                acc_nxt = or_val;
                acc_hit = 1'b1;
                zero_nxt = (or_val == {DATA_W{1'b0}});
              end
              default:
                unsup_nxt = 1'b1;
            endcase
          end
        end
      end
      S_RD:
        state_nxt = S_DATA;
      S_DATA:
      begin
        state_nxt = S_IDLE;
        retire_nxt = 1'b1;
        if (dest_r)
        begin
          wdata_nxt = result;
          file_wr_nxt = 1'b1;
        end
        else
        begin
          acc_nxt = result;
          acc_hit = 1'b1;
        end
        // The skip forms leave the zero flag alone; only the pending skip records their result.
        if (op_r == OP_DEC)
          zero_nxt = (result == {DATA_W{1'b0}});
        else
          skip_nxt = (result == {DATA_W{1'b0}});
      end
      default:
        state_nxt = S_IDLE;
    endcase
    // A software write to the accumulator yields to an instruction writing it the same cycle.
    if (bus_wr_i && bus_addr_i == `REG_ACC_OFS && !acc_hit)
      acc_nxt = bus_wdata_i[DATA_W-1:0];
    // Ready is registered, so a word is never accepted while an operand read is in flight.
    ready_nxt = enable_nxt && (state_nxt == S_IDLE);
    rdata_nxt = 32'h00000000;
    if (bus_rd_i)
    begin
      case (bus_addr_i)
        `REG_CTRL_OFS:
          rdata_nxt[`CTRL_ENABLE_BIT] = enable_r;
        `REG_ACC_OFS:
          rdata_nxt[DATA_W-1:0] = acc_r;
        `REG_STATUS_OFS:
        begin
          rdata_nxt[`STATUS_ZERO_BIT] = zero_r;
          rdata_nxt[`STATUS_SKIP_BIT] = skip_r;
          rdata_nxt[`STATUS_UNSUP_BIT] = unsup_r;
          rdata_nxt[`STATUS_BUSY_BIT] = (state_r != S_IDLE);
        end
        default:
          rdata_nxt[PC_W-1:0] = pc_r;
      endcase
    end
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_r <= S_IDLE;
      op_r <= OP_NONE;
      dest_r <= 1'b0;
      addr_r <= {ADDR_W{1'b0}};
      acc_r <= `ACC_RESET;
      zero_r <= `ZERO_RESET;
      pc_r <= `PC_RESET;
      pc_load_r <= 1'b0;
      file_rd_r <= 1'b0;
      file_wr_r <= 1'b0;
      wdata_r <= {DATA_W{1'b0}};
      skip_r <= 1'b0;
      retire_r <= 1'b0;
      discard_r <= 1'b0;
      unsup_r <= 1'b0;
      enable_r <= `CTRL_RESET;
      ready_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      dest_r <= dest_nxt;
      addr_r <= addr_nxt;
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
      pc_r <= pc_nxt;
      pc_load_r <= pc_load_nxt;
      file_rd_r <= file_rd_nxt;
      file_wr_r <= file_wr_nxt;
      wdata_r <= wdata_nxt;
      skip_r <= skip_nxt;
      retire_r <= retire_nxt;
      discard_r <= discard_nxt;
      unsup_r <= unsup_nxt;
      enable_r <= enable_nxt;
      ready_r <= ready_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign instr_ready_o = ready_r;
  assign pc_o = pc_r;
  assign pc_load_o = pc_load_r;
  assign file_addr_o = addr_r;
  assign file_rd_o = file_rd_r;
  assign file_wr_o = file_wr_r;
  assign file_wdata_o = wdata_r;
  assign acc_o = acc_r;
  assign zero_o = zero_r;
  assign retire_o = retire_r;
  assign discard_o = discard_r;
  assign bus_rdata_o = rdata_r;

endmodule
`default_nettype wire

// file: instr_subset_consts.vh
// Constants for the instruction subset executor: offsets, opcode patterns, reset values.
`ifndef INSTR_SUBSET_CONSTS_VH
`define INSTR_SUBSET_CONSTS_VH

`define REG_CTRL_OFS 2'h0
`define REG_ACC_OFS 2'h1
`define REG_STATUS_OFS 2'h2
`define REG_PC_OFS 2'h3

`define CTRL_ENABLE_BIT 0
`define STATUS_ZERO_BIT 0
`define STATUS_SKIP_BIT 1
`define STATUS_UNSUP_BIT 2
`define STATUS_BUSY_BIT 3

`define CTRL_RESET 1'h1
`define ACC_RESET 8'h00
`define ZERO_RESET 1'h0
`define PC_RESET 13'h0000

`define CLEAR_ACC_MASK 14'h3f80
`define CLEAR_ACC_PAT 14'h0100
`define CLEAR_FILE_MASK 14'h3f80
`define CLEAR_FILE_PAT 14'h0180
`define DEC_MASK 14'h3f00
`define DEC_PAT 14'h0300
`define DEC_SKIP_MASK 14'h3f00
`define DEC_SKIP_PAT 14'h0b00
`define INC_SKIP_MASK 14'h3f00
`define INC_SKIP_PAT 14'h0f00
`define BRANCH_MASK 14'h3800
`define BRANCH_PAT 14'h2800
`define OR_LIT_MASK 14'h3f00
`define OR_LIT_PAT 14'h3800

`define DEST_BIT 7
`define UPPER_LATCH_HI 4
`define UPPER_LATCH_LO 3

`endif

// file: exec_checker_properties.sv
// Checker that ties executor outputs to the accepted instruction words.
`timescale 1ns/1ps
`default_nettype none
module exec_checker (
  input wire clk_i,
  input wire reset_i,
  input wire instr_valid_i,
  input wire [13:0] instr_i,
  input wire instr_ready_o,
  input wire [12:0] pc_o,
  input wire pc_load_o,
  input wire [7:0] pc_upper_latch_i,
  input wire file_wr_o,
  input wire file_rd_o,
  input wire [6:0] file_addr_o,
  input wire [7:0] file_wdata_o,
  input wire [7:0] acc_o,
  input wire zero_o,
  input wire retire_o,
  input wire discard_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // A discarded word has no effect, so discard_o excuses every result check except branch_flag_a.
  wire take = instr_valid_i & instr_ready_o;
  wire [5:0] op = instr_i[13:8];
  wire skop = op == 6'h0b || op == 6'h0f;
  clear_acc_a: assert property (take && instr_i[13:7] == 7'h02 |=> discard_o || acc_o == 8'h00 && zero_o)
    else $error("clear acc wrong");
  clear_file_a: assert property (take && instr_i[13:7] == 7'h03 |=> discard_o || file_wr_o && file_wdata_o == 8'h00 && zero_o)
    else $error("clear file wrong");
  dec_zero_a: assert property (take && op == 6'h03 |=> (discard_o or ##2 (retire_o && zero_o == ((file_wr_o ? file_wdata_o : acc_o) == 8'h00))))
    else $error("dec zero wrong");
  rmw_route_a: assert property (take && (op == 6'h03 || skop) |=> (discard_o or ##2 (retire_o && file_wr_o == $past(instr_i[7], 3))))
    else $error("route wrong");
  rmw_fetch_a: assert property (take && (op == 6'h03 || skop) |=> discard_o || file_rd_o && file_addr_o == $past(instr_i[6:0]))
    else $error("operand fetch wrong");
  skip_flags_a: assert property (take && skop |=> (discard_o or ##2 (zero_o == $past(zero_o, 3))))
    else $error("skip flag moved");
  or_literal_a: assert property (take && op == 6'h38 |=> discard_o || acc_o == ($past(acc_o) | $past(instr_i[7:0])) && zero_o == (acc_o == 8'h00))
    else $error("or literal wrong");
  branch_pc_a: assert property (take && instr_i[13:11] == 3'h5 |=> discard_o || pc_load_o && pc_o == {$past(pc_upper_latch_i[4:3]), $past(instr_i[10:0])})
    else $error("branch pc wrong");
  branch_flag_a: assert property (take && instr_i[13:11] == 3'h5 |=> $stable(zero_o))
    else $error("branch flag moved");
  discard_nop_a: assert property (discard_o |-> retire_o && !file_wr_o && $stable(zero_o))
    else $error("discard had effect");
endmodule
bind core_instr_subset_exec exec_checker exec_checker_inst (.clk_i, .reset_i, .instr_valid_i, .instr_i, .instr_ready_o,
  .pc_o, .pc_load_o, .pc_upper_latch_i, .file_wr_o, .file_rd_o, .file_addr_o, .file_wdata_o, .acc_o, .zero_o,
  .retire_o, .discard_o);
`default_nettype wire

// file: file_model.sv
// Model of the data register file beside the executor.
`timescale 1ns/1ps
`default_nettype none
module file_model (
  input wire logic clk_i,
  input wire logic [6:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:127];
  initial rdata_o = 8'h5a;
  // Data stands only the cycle after the strobe; it toggles otherwise so stale data never passes.
  always @(posedge clk_i)
  begin
    if (wr_i)
      mem[addr_i] <= wdata_i;
    rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the instruction subset executor.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic [7:0] pc_upper_latch_i = 8'h00;
  logic [1:0] bus_addr_i = 2'h0;
  logic [31:0] bus_wdata_i = 32'h00000000;
  logic bus_wr_i = 1'b0;
  logic bus_rd_i = 1'b0;
  wire instr_ready_o, pc_load_o, file_rd_o, file_wr_o, zero_o, retire_o, discard_o;
  wire [12:0] pc_o;
  wire [6:0] file_addr_o;
  wire [7:0] file_rdata_i, file_wdata_o, acc_o;
  wire [31:0] bus_rdata_o;
  wire [15:0] az = {7'h00, zero_o, acc_o};
  int fail_count = 0;
  int checked = 0;
  logic disc;
  logic ld;
  always #4 clk_i = ~clk_i;
  core_instr_subset_exec core_instr_subset_exec_inst (.clk_i, .reset_i, .instr_valid_i, .instr_i, .instr_ready_o,
    .pc_o, .pc_load_o, .pc_upper_latch_i, .file_addr_o, .file_rd_o, .file_rdata_i, .file_wr_o, .file_wdata_o,
    .acc_o, .zero_o, .retire_o, .discard_o, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_rd_i, .bus_rdata_o);
  file_model file_model_inst (.clk_i, .addr_i(file_addr_o), .rd_i(file_rd_o), .wr_i(file_wr_o),
    .wdata_i(file_wdata_o), .rdata_o(file_rdata_i));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Offers one word, holds it until taken, then waits for its retire pulse.
  task rc(input logic [13:0] w, input logic [15:0] e);
    int n;
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    @(posedge clk_i);
    for (n = 0; n < 8 && instr_ready_o !== 1'b1; n++)
      @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
    for (n = 0; n < 8 && retire_o !== 1'b1; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    disc = discard_o;
    ld = pc_load_o;
    chk({15'h0000, retire_o}, 16'h0001);
    chk(az, e);
  endtask
  // The file takes a write at the edge after its strobe, so memory is looked at one edge later.
  task mchk(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk_i);
    #1;
    chk({8'h00, file_model_inst.mem[a]}, {8'h00, e});
  endtask
  task bus_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_wr_i <= 1'b1;
    bus_addr_i <= a;
    bus_wdata_i <= d;
    @(posedge clk_i);
    bus_wr_i <= 1'b0;
  endtask
  task rdchk(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk_i);
    bus_rd_i <= 1'b1;
    bus_addr_i <= a;
    @(posedge clk_i);
    bus_rd_i <= 1'b0;
    #1;
    chk(bus_rdata_o[15:0], e);
  endtask
  initial
  begin
    file_model_inst.mem[5] = 8'h01;
    file_model_inst.mem[10] = 8'h03;
    file_model_inst.mem[127] = 8'hff;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rdchk(2'h0, 16'h0001);
    rdchk(2'h1, 16'h0000);
    rc(14'h3800, 16'h0100);
    rc(14'h38a5, 16'h00a5);
    rc(14'h385a, 16'h00ff);
    rc(14'h0100, 16'h0100);
    bus_wr(2'h1, 32'h0000003c);
    rdchk(2'h1, 16'h003c);
    rc(14'h030a, 16'h0002);
    rc(14'h0300 | 14'h000a, 16'h0002);
    mchk(7'h0a, 8'h03);
    rc(14'h0385, 16'h0102);
    mchk(7'h05, 8'h00);
    rc(14'h3801, 16'h0003);
    rc(14'h018a, 16'h0103);
    mchk(7'h0a, 8'h00);
    rc(14'h3800, 16'h0003);
    rc(14'h0fff, 16'h0003);
    mchk(7'h7f, 8'h00);
    rc(14'h38f0, 16'h0003);
    chk({15'h0000, disc}, 16'h0001);
    rc(14'h0b0a, 16'h00ff);
    rc(14'h3800, 16'h00ff);
    chk({15'h0000, disc}, 16'h0000);
    @(posedge clk_i);
    pc_upper_latch_i <= 8'h18;
    rc(14'h2fff, 16'h00ff);
    chk({3'h0, pc_o}, 16'h1fff);
    chk({15'h0000, ld}, 16'h0001);
    rc(14'h3800, 16'h00ff);
    chk({15'h0000, disc}, 16'h0001);
    @(posedge clk_i);
    pc_upper_latch_i <= 8'he7;
    rc(14'h2923, 16'h00ff);
    bus_wr(2'h3, 32'h00001fff);
    rdchk(2'h3, 16'h0123);
    rc(14'h3f00, 16'h00ff);
    chk({15'h0000, disc}, 16'h0001);
    rc(14'h3f00, 16'h00ff);
    rdchk(2'h2, 16'h0004);
    summarize();
  end
  initial
  begin
    #20000;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
